// ==== src/pshp_cfg.svh ====
// Offsets, field positions, reset values and counts of the pulse shaper.
`ifndef PSHP_CFG_SVH
`define PSHP_CFG_SVH
`define PSHP_IDX_LINE_CFG   8'hF0
`define PSHP_IDX_CTRL_STAT  8'hF1
`define PSHP_IDX_WR_ADDR    8'hF2
`define PSHP_IDX_WR_DATA    8'hF3
`define PSHP_CFG_FLOAT_BIT  7
`define PSHP_CFG_SCALE_LSB  0
`define PSHP_CFG_FLOAT_RST  1'h1
`define PSHP_CFG_SCALE_RST  5'h00
`define PSHP_CS_OVF_BIT     2
`define PSHP_CS_RSV1_BIT    1
`define PSHP_CS_RSV0_BIT    0
`define PSHP_CS_RSV1_RST    1'h0
`define PSHP_CS_RSV0_RST    1'h1
`define PSHP_WA_UI_LSB      0
`define PSHP_WA_SMP_LSB     3
`define PSHP_WA_RST         8'h00
`define PSHP_NUM_UI         5
`define PSHP_NUM_SMP        24
`define PSHP_SCALE_MAX      5'h15
`define PSHP_DAC_MAX        10'sh07F
`define PSHP_DAC_MIN        -10'sh080
`define PSHP_SAMPLE_DIV     16
`define PSHP_RESP_OKAY      2'h0
`define PSHP_RESP_SLVERR    2'h2
`endif

// ==== src/pshp_pkg.sv ====
// Types of the pulse shaper.
`default_nettype none
package pshp_pkg;
    typedef logic [119:0][6:0] pshp_tmpl_t;
    typedef logic signed [9:0] pshp_sum_t;

    typedef struct packed {
        logic        aw_full;
        logic [11:0] aw_addr;
        logic        w_full;
        logic [31:0] w_data;
        logic        w_lane0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } pshp_bus_t;

    typedef struct packed {
        logic        float_out;
        logic [4:0]  scale;
        logic        rsv1;
        logic        rsv0;
        logic        ovf;
        logic [7:0]  waddr;
        pshp_tmpl_t  tmpl;
        logic [15:0] div_cnt;
        logic [4:0]  smp;
        logic [4:0]  hist_mark;
        logic [4:0]  hist_neg;
        logic [7:0]  dac;
    } pshp_core_t;

    typedef struct packed {
        pshp_bus_t  bus;
        pshp_core_t core;
    } pshp_state_t;
endpackage
`default_nettype wire

// ==== src/pshp_shaper.sv ====
// Transmit pulse shaper: template store, summing, clamp, output control.
`default_nettype none
`include "pshp_cfg.svh"
module pshp_shaper #(
    parameter int SAMPLE_DIV = `PSHP_SAMPLE_DIV
) (
    // Clock and reset.
    input  wire logic        i_ref_clk,
    input  wire logic        i_nrst,
    // Transmit interface hold from the interface configuration.
    input  wire logic        i_tx_interface_hold,
    // AXI4-Lite write channels.
    input  wire logic [11:0] i_axi_awaddr,
    input  wire logic        i_axi_awvalid,
    output logic             o_axi_awready,
    input  wire logic [31:0] i_axi_wdata,
    input  wire logic [3:0]  i_axi_wstrb,
    input  wire logic        i_axi_wvalid,
    output logic             o_axi_wready,
    output logic [1:0]       o_axi_bresp,
    output logic             o_axi_bvalid,
    input  wire logic        i_axi_bready,
    // AXI4-Lite read channels.
    input  wire logic [11:0] i_axi_araddr,
    input  wire logic        i_axi_arvalid,
    output logic             o_axi_arready,
    output logic [31:0]      o_axi_rdata,
    output logic [1:0]       o_axi_rresp,
    output logic             o_axi_rvalid,
    input  wire logic        i_axi_rready,
    // Bit stream to be shaped.
    input  wire logic        i_tx_mark,
    input  wire logic        i_tx_neg,
    output logic             o_tx_take,
    // Converter and line driver.
    output logic [7:0]       o_dac_code,
    output logic [4:0]       o_dac_scale,
    output logic             o_line_out_pos,
    output logic             o_line_out_pos_oe,
    output logic             o_line_out_neg,
    output logic             o_line_out_neg_oe
);
    localparam logic [11:0] A_CFG = {2'h0, `PSHP_IDX_LINE_CFG, 2'h0};
    localparam logic [11:0] A_CS  = {2'h0, `PSHP_IDX_CTRL_STAT, 2'h0};
    localparam logic [11:0] A_WA  = {2'h0, `PSHP_IDX_WR_ADDR, 2'h0};
    localparam logic [11:0] A_WD  = {2'h0, `PSHP_IDX_WR_DATA, 2'h0};
    localparam logic [15:0] DIV_LAST = 16'(SAMPLE_DIV - 1);
    localparam logic [4:0]  SMP_LAST = 5'(`PSHP_NUM_SMP - 1);
    localparam logic [2:0]  UI_NUM   = 3'(`PSHP_NUM_UI);
    localparam logic [4:0]  SMP_NUM  = 5'(`PSHP_NUM_SMP);

    localparam pshp_pkg::pshp_core_t CORE_RST = '{
        float_out: `PSHP_CFG_FLOAT_RST,
        scale:     `PSHP_CFG_SCALE_RST,
        rsv1:      `PSHP_CS_RSV1_RST,
        rsv0:      `PSHP_CS_RSV0_RST,
        waddr:     `PSHP_WA_RST,
        default:   '0
    };

    pshp_pkg::pshp_state_t q;
    pshp_pkg::pshp_state_t n;
    pshp_pkg::pshp_sum_t   sum;
    logic                  smp_en;
    logic                  wr_go;
    logic                  rd_go;
    logic                  rd_cs;
    logic                  ovf_evt;
    logic                  drive;
    logic [4:0]            eff_scale;

    // Signed sum of one sample position over the five intervals.
    function automatic pshp_pkg::pshp_sum_t shape_sum(
        input pshp_pkg::pshp_core_t c
    );
        pshp_pkg::pshp_sum_t acc;
        pshp_pkg::pshp_sum_t tc;
        logic [6:0]          v;
        logic [6:0]          idx;
        acc = '0;
        for (int k = 0; k < `PSHP_NUM_UI; k++) begin
            idx = 7'(k * `PSHP_NUM_SMP) + {2'h0, c.smp};
            v   = c.tmpl[idx];
            tc  = v[6] ? -$signed({4'h0, v[5:0]})
                       : $signed({4'h0, v[5:0]});
            if (c.hist_mark[k]) begin
                acc = c.hist_neg[k] ? acc - tc : acc + tc;
            end
        end
        return acc;
    endfunction

    function automatic logic [31:0] read_mux(
        input logic [11:0] a,
        input pshp_pkg::pshp_core_t c
    );
        logic [31:0] d;
        d = '0;
        case (a)
            A_CFG: begin
                d[`PSHP_CFG_FLOAT_BIT] = c.float_out;
                d[`PSHP_CFG_SCALE_LSB +: 5] = c.scale;
            end
            A_CS: begin
                d[`PSHP_CS_OVF_BIT]  = c.ovf;
                d[`PSHP_CS_RSV1_BIT] = c.rsv1;
                d[`PSHP_CS_RSV0_BIT] = c.rsv0;
            end
            A_WA:    d[7:0] = c.waddr;
            default: d = '0;
        endcase
        return d;
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        return (a == A_CFG) || (a == A_CS) || (a == A_WA) || (a == A_WD);
    endfunction

    assign o_axi_awready = !q.bus.aw_full && !q.bus.bvalid;
    assign o_axi_wready  = !q.bus.w_full && !q.bus.bvalid;
    assign o_axi_arready = !q.bus.rvalid;
    assign o_axi_bvalid  = q.bus.bvalid;
    assign o_axi_bresp   = q.bus.bresp;
    assign o_axi_rvalid  = q.bus.rvalid;
    assign o_axi_rresp   = q.bus.rresp;
    assign o_axi_rdata   = q.bus.rdata;

    assign smp_en    = (q.core.div_cnt == DIV_LAST);
    assign o_tx_take = smp_en && (q.core.smp == SMP_LAST) &&
                       !i_tx_interface_hold;
    assign eff_scale = (q.core.scale > `PSHP_SCALE_MAX) ? `PSHP_SCALE_MAX
                                                       : q.core.scale;
    assign drive     = !q.core.float_out && (q.core.scale != 5'h00);
    assign o_dac_scale       = drive ? eff_scale : 5'h00;
    assign o_dac_code        = q.core.dac;
    assign o_line_out_pos    = drive && !q.core.dac[7] && (q.core.dac != 8'h00);
    assign o_line_out_neg    = drive && q.core.dac[7];
    assign o_line_out_pos_oe = drive;
    assign o_line_out_neg_oe = drive;

    assign sum     = shape_sum(q.core);
    assign ovf_evt = smp_en && ((sum > `PSHP_DAC_MAX) ||
                                (sum < `PSHP_DAC_MIN));
    assign wr_go   = q.bus.aw_full && q.bus.w_full && !q.bus.bvalid;
    assign rd_go   = i_axi_arvalid && !q.bus.rvalid;
    assign rd_cs   = rd_go && (i_axi_araddr == A_CS);

    always_comb begin
        n = q;
        if (o_axi_awready && i_axi_awvalid) begin
            n.bus.aw_full = 1'b1;
            n.bus.aw_addr = i_axi_awaddr;
        end
        if (o_axi_wready && i_axi_wvalid) begin
            n.bus.w_full  = 1'b1;
            n.bus.w_data  = i_axi_wdata;
            n.bus.w_lane0 = i_axi_wstrb[0];
        end
        if (q.bus.bvalid && i_axi_bready) begin
            n.bus.bvalid = 1'b0;
        end
        if (wr_go) begin
            n.bus.aw_full = 1'b0;
            n.bus.w_full  = 1'b0;
            n.bus.bvalid  = 1'b1;
            n.bus.bresp   = mapped(q.bus.aw_addr) ? `PSHP_RESP_OKAY
                                                  : `PSHP_RESP_SLVERR;
        end
        if (q.bus.rvalid && i_axi_rready) begin
            n.bus.rvalid = 1'b0;
        end
        if (rd_go) begin
            n.bus.rvalid = 1'b1;
            n.bus.rdata  = read_mux(i_axi_araddr, q.core);
            n.bus.rresp  = mapped(i_axi_araddr) ? `PSHP_RESP_OKAY
                                                : `PSHP_RESP_SLVERR;
        end
        if (i_tx_interface_hold) begin
            n.core = CORE_RST;
        end else begin
            if (wr_go && q.bus.w_lane0) begin
                case (q.bus.aw_addr)
                    A_CFG: begin
                        n.core.float_out = q.bus.w_data[`PSHP_CFG_FLOAT_BIT];
                        n.core.scale = q.bus.w_data[`PSHP_CFG_SCALE_LSB +: 5];
                    end
                    A_CS: begin
                        n.core.rsv1 = q.bus.w_data[`PSHP_CS_RSV1_BIT];
                        n.core.rsv0 = q.bus.w_data[`PSHP_CS_RSV0_BIT];
                    end
                    A_WA: n.core.waddr = q.bus.w_data[7:0];
                    A_WD: begin
                        // Undefined selector codes leave the store alone.
                        if (q.core.waddr[`PSHP_WA_UI_LSB +: 3] < UI_NUM &&
                            q.core.waddr[`PSHP_WA_SMP_LSB +: 5] < SMP_NUM)
                        begin
                            n.core.tmpl[7'(q.core.waddr[2:0] *
                                           `PSHP_NUM_SMP) +
                                        {2'h0, q.core.waddr[7:3]}] =
                                q.bus.w_data[6:0];
                        end
                    end
                    default: n.core.ovf = q.core.ovf;
                endcase
            end
            n.core.div_cnt = smp_en ? 16'h0000 : q.core.div_cnt + 16'h0001;
            if (smp_en) begin
                if (sum > `PSHP_DAC_MAX) begin
                    n.core.dac = 8'(`PSHP_DAC_MAX);
                end else if (sum < `PSHP_DAC_MIN) begin
                    n.core.dac = 8'(`PSHP_DAC_MIN);
                end else begin
                    n.core.dac = sum[7:0];
                end
                if (q.core.smp == SMP_LAST) begin
                    n.core.smp = 5'h00;
                    n.core.hist_mark = {q.core.hist_mark[3:0], i_tx_mark};
                    n.core.hist_neg  = {q.core.hist_neg[3:0], i_tx_neg};
                end else begin
                    n.core.smp = q.core.smp + 5'h01;
                end
            end
            if (rd_cs) begin
                n.core.ovf = 1'b0;
            end
            if (ovf_evt) begin
                n.core.ovf = 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            q.bus  <= '0;
            q.core <= CORE_RST;
        end else begin
            q <= n;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    logic [6:0] wr_idx;
    assign wr_idx = 7'(q.core.waddr[2:0] * `PSHP_NUM_SMP) +
                    {2'h0, q.core.waddr[7:3]};

    sequence s_data_write;
        wr_go && q.bus.w_lane0 && (q.bus.aw_addr == A_WD) &&
        !i_tx_interface_hold;
    endsequence

    property p_hold_reset;
        i_tx_interface_hold |=> q.core.float_out && (q.core.scale == 5'h00)
            && !q.core.ovf && (q.core.waddr == 8'h00) && !o_line_out_pos_oe;
    endproperty
    a_hold_reset: assert property (p_hold_reset)
        else $error("hold did not reset shaper state");

    property p_float_off;
        q.core.float_out |-> !o_line_out_pos_oe && !o_line_out_neg_oe;
    endproperty
    a_float_off: assert property (p_float_off)
        else $error("line driven while float bit set");

    property p_float_as_zero;
        (q.core.float_out || q.core.scale == 5'h00) |->
            (o_dac_scale == 5'h00) && !o_line_out_neg_oe;
    endproperty
    a_float_as_zero: assert property (p_float_as_zero)
        else $error("float does not match zero scale");

    property p_scale_cap;
        o_line_out_pos_oe |-> (o_dac_scale != 5'h00) &&
            (o_dac_scale <= `PSHP_SCALE_MAX);
    endproperty
    a_scale_cap: assert property (p_scale_cap)
        else $error("effective scale out of range");

    property p_ovf_set;
        ovf_evt && !i_tx_interface_hold |=> q.core.ovf;
    endproperty
    a_ovf_set: assert property (p_ovf_set)
        else $error("overflow not flagged");

    property p_clamp;
        smp_en && (sum > `PSHP_DAC_MAX) && !i_tx_interface_hold |=>
            (o_dac_code == 8'h7F);
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("positive overflow not clamped");

    property p_ovf_read_clear;
        rd_cs && !ovf_evt |=> !q.core.ovf && q.bus.rvalid;
    endproperty
    a_ovf_read_clear: assert property (p_ovf_read_clear)
        else $error("status read did not clear overflow");

    property p_ovf_sticky;
        q.core.ovf && !rd_cs && !i_tx_interface_hold |=> q.core.ovf;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky)
        else $error("overflow flag dropped without a read");

    property p_tmpl_store;
        logic [6:0] ix;
        logic [6:0] vv;
        (s_data_write and (q.core.waddr[2:0] < UI_NUM &&
         q.core.waddr[7:3] < SMP_NUM), ix = wr_idx, vv = q.bus.w_data[6:0])
            |=> (q.core.tmpl[ix] == vv);
    endproperty
    a_tmpl_store: assert property (p_tmpl_store)
        else $error("template entry not stored");

    property p_bad_ui;
        s_data_write and (q.core.waddr[2:0] >= UI_NUM) |=>
            $stable(q.core.tmpl);
    endproperty
    a_bad_ui: assert property (p_bad_ui)
        else $error("undefined interval code changed the store");

endmodule
`default_nettype wire

// ==== tb/pshp_dac_model.sv ====
// Behavioural line driver converter that the pulse shaper feeds.
`default_nettype none
module pshp_dac_model (
    // Clock.
    input  wire logic          i_ref_clk,
    // Converter code, amplitude and line enables.
    input  wire logic [7:0]    i_dac_code,
    input  wire logic [4:0]    i_dac_scale,
    input  wire logic          i_pos_oe,
    input  wire logic          i_neg_oe,
    // Line current in converter steps.
    output logic signed [15:0] o_level
);
    timeunit 1ns;
    timeprecision 1ns;
    // A floated pair carries no current, whatever code arrives.
    always_ff @(posedge i_ref_clk) begin
        if (i_pos_oe && i_neg_oe) begin
            o_level <= $signed(i_dac_code) *
                       $signed({1'b0, i_dac_scale});
        end else begin
            o_level <= 16'sh0000;
        end
    end
endmodule
`default_nettype wire

// ==== tb/test_tx_pulse_template_shaper.sv ====
// Self-checking bench of the pulse shaper: bus, shaping, clamp and hold.
`default_nettype none
module test_tx_pulse_template_shaper;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int          SD    = 2;
    localparam logic [11:0] A_CFG = 12'h3C0;
    localparam logic [11:0] A_CS  = 12'h3C4;
    localparam logic [11:0] A_WA  = 12'h3C8;
    localparam logic [11:0] A_WD  = 12'h3CC;
    logic               clk, nrst, hold, awv, wv, bry, arv, rry, mark, neg;
    logic               awry, wry, bv, arry, rv, take, pos, poe, ngo, noe;
    logic [11:0]        awa, ara;
    logic [31:0]        wd, rd;
    logic [3:0]         ws;
    logic [1:0]         br, rr;
    logic [7:0]         code;
    logic [4:0]         scl;
    logic signed [15:0] lvl;
    int                 err_total, n_tests, cyc;

    pshp_shaper #(.SAMPLE_DIV(SD)) pshp_shaper_inst (
        .i_ref_clk(clk), .i_nrst(nrst), .i_tx_interface_hold(hold),
        .i_axi_awaddr(awa), .i_axi_awvalid(awv), .o_axi_awready(awry),
        .i_axi_wdata(wd), .i_axi_wstrb(ws), .i_axi_wvalid(wv),
        .o_axi_wready(wry), .o_axi_bresp(br), .o_axi_bvalid(bv),
        .i_axi_bready(bry), .i_axi_araddr(ara), .i_axi_arvalid(arv),
        .o_axi_arready(arry), .o_axi_rdata(rd), .o_axi_rresp(rr),
        .o_axi_rvalid(rv), .i_axi_rready(rry), .i_tx_mark(mark),
        .i_tx_neg(neg), .o_tx_take(take), .o_dac_code(code),
        .o_dac_scale(scl), .o_line_out_pos(pos), .o_line_out_pos_oe(poe),
        .o_line_out_neg(ngo), .o_line_out_neg_oe(noe));
    pshp_dac_model pshp_dac_model_inst (
        .i_ref_clk(clk), .i_dac_code(code), .i_dac_scale(scl),
        .i_pos_oe(poe), .i_neg_oe(noe), .o_level(lvl));

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      input logic [1:0] eb = 2'h0,
                      input logic [3:0] st = 4'hF);
        logic       ah, wh, b;
        logic [1:0] r;
        @(posedge clk);
        awa <= a;
        wd <= {24'h000000, d};
        ws <= st;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do begin
            @(negedge clk);
            ah = awv & awry;
            wh = wv & wry;
            @(posedge clk);
            if (ah) awv <= 1'b0;
            if (wh) wv <= 1'b0;
        end while (awv | wv);
        do begin
            @(negedge clk);
            b = bv;
            r = br;
            @(posedge clk);
        end while (!b);
        bry <= 1'b0;
        chk("bresp", {30'h0, eb}, {30'h0, r});
    endtask
    task automatic rc(input string nm, input logic [11:0] a,
                      input logic [7:0] e, input logic [1:0] er);
        logic       h;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(negedge clk);
            h = arry;
            @(posedge clk);
        end while (!h);
        arv <= 1'b0;
        do begin
            @(negedge clk);
            h = rv;
            d = rd;
            r = rr;
            @(posedge clk);
        end while (!h);
        rry <= 1'b0;
        chk(nm, {24'h000000, e}, d);
        chk({nm, " resp"}, {30'h0, er}, {30'h0, r});
    endtask
    task automatic fill(input logic [2:0] ui, input logic [6:0] v);
        for (int s = 0; s < 24; s++) begin
            wr(A_WA, {s[4:0], ui});
            wr(A_WD, {1'b0, v});
        end
    endtask
    // Waits until every interval of the history has refreshed, then
    // watches one whole interval so that each sample position is seen.
    task automatic steady(input string nm, input logic [7:0] e);
        repeat (6 * 24 * SD) @(posedge clk);
        repeat (24 * SD) begin
            @(negedge clk);
            chk(nm, {24'h000000, e}, {24'h000000, code});
        end
    endtask
    task automatic t_reset;
        @(negedge clk);
        chk("oe after reset", 32'h0, {30'h0, poe, noe});
        rc("cfg", A_CFG, 8'h80, 2'h0);
        rc("status", A_CS, 8'h01, 2'h0);
        rc("waddr", A_WA, 8'h00, 2'h0);
        rc("wdata", A_WD, 8'h00, 2'h0);
        wr(12'h000, 8'hFF, 2'h2);
        rc("unmapped", 12'h000, 8'h00, 2'h2);
        $display("test reset done");
    endtask
    task automatic t_scale;
        logic [7:0] v[5] = '{8'h05, 8'h85, 8'h1F, 8'h00, 8'h15};
        logic       e;
        logic [4:0] s;
        for (int i = 0; i < 5; i++) begin
            wr(A_CFG, v[i]);
            @(negedge clk);
            e = !v[i][7] && (v[i][4:0] != 5'h00);
            s = (v[i][4:0] > 5'h15) ? 5'h15 : v[i][4:0];
            chk("line oe", {30'h0, e, e}, {30'h0, poe, noe});
            chk("scale", {27'h0, e ? s : 5'h00}, {27'h0, scl});
        end
        wr(A_CFG, 8'h85, 2'h0, 4'h0);
        rc("cfg", A_CFG, 8'h15, 2'h0);
        $display("test scale done");
    endtask
    task automatic t_shape;
        logic [31:0] k;
        fill(3'h0, 7'h0A);
        fill(3'h1, 7'h14);
        wr(A_WA, 8'h05);
        wr(A_WD, 8'h3F);
        wr(A_WA, 8'hC0);
        wr(A_WD, 8'h3F);
        @(posedge clk);
        mark <= 1'b1;
        steady("sum pos", 8'h1E);
        chk("line pos", 32'h2, {30'h0, pos, ngo});
        chk("level", 32'h0276, {16'h0, lvl});
        k = 32'h0;
        repeat (2 * 24 * SD) begin
            @(negedge clk);
            k = k + {31'h0, take};
        end
        chk("take per interval", 32'h2, k);
        @(posedge clk);
        neg <= 1'b1;
        steady("sum neg", 8'hE2);
        chk("line neg", 32'h1, {30'h0, pos, ngo});
        fill(3'h1, 7'h54);
        neg <= 1'b0;
        steady("mixed sign", 8'hF6);
        $display("test shape done");
    endtask
    task automatic t_ovf;
        fill(3'h0, 7'h3F);
        fill(3'h1, 7'h3F);
        fill(3'h2, 7'h3F);
        steady("clamp hi", 8'h7F);
        rc("status ovf", A_CS, 8'h05, 2'h0);
        neg <= 1'b1;
        steady("clamp lo", 8'h80);
        @(posedge clk);
        mark <= 1'b0;
        steady("idle", 8'h00);
        rc("status sticky", A_CS, 8'h05, 2'h0);
        rc("status cleared", A_CS, 8'h01, 2'h0);
        $display("test overflow done");
    endtask
    task automatic t_hold;
        @(posedge clk);
        hold <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("hold code", 32'h0, {24'h0, code});
        chk("hold oe", 32'h0, {30'h0, poe, noe});
        wr(A_CFG, 8'h15);
        rc("hold cfg", A_CFG, 8'h80, 2'h0);
        hold <= 1'b0;
        rc("cfg after hold", A_CFG, 8'h80, 2'h0);
        mark <= 1'b1;
        steady("cleared store", 8'h00);
        $display("test hold done");
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            err_total++;
            conclude;
        end
    end
    initial begin
        {nrst, hold, awv, wv, bry, arv, rry, mark, neg} = 9'h000;
        awa = 12'h000;
        ara = 12'h000;
        wd = 32'h00000000;
        ws = 4'h0;
        err_total = 0;
        n_tests = 0;
        cyc = 0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        t_reset;
        t_scale;
        t_shape;
        t_ovf;
        t_hold;
        conclude;
    end
endmodule
`default_nettype wire
